// >>> src/dtb_pkg.sv
// Constants, types and helpers shared by the dual timer and rate generator block.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package dtb_pkg;

   //---------------------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   //---------------------------------------------------------------------------
   localparam logic [7:0] IDX_A_LOW = 8'h18; // Counter A low byte, latch A low.
   localparam logic [7:0] IDX_A_HIGH = 8'h19; // Counter A high byte, latch A high.
   localparam logic [7:0] IDX_A_LOAD = 8'h1a; // Counter A low read, load-and-start write.
   localparam logic [7:0] IDX_B_LOW = 8'h1c; // timer_b_low_access.
   localparam logic [7:0] IDX_B_HIGH = 8'h1d; // timer_b_high_access.
   localparam logic [7:0] IDX_B_LOAD = 8'h1e; // timer_b_load_start.
   localparam logic [7:0] IDX_MODE = 8'h20; // mode_control.
   localparam logic [7:0] IDX_INT_EN = 8'h21; // interrupt_enable.
   localparam logic [7:0] IDX_INT_FLAG = 8'h22; // interrupt_flags.
   localparam logic [7:0] IDX_PORT_A = 8'h23; // Port A latch.
   localparam logic [7:0] IDX_PORT_B = 8'h24; // Port B latch.
   localparam logic [7:0] IDX_STATUS = 8'h25; // Processor status copy.
   localparam logic [7:0] IDX_SERIAL = 8'h26; // Serial channel enable.

   //---------------------------------------------------------------------------
   // Reset values, field positions and mode codes.
   //---------------------------------------------------------------------------
   localparam logic [7:0] MODE_RST = 8'he0;
   localparam logic [7:0] INT_EN_RST = 8'h00;
   localparam logic [7:0] INT_FLAG_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'hff;
   localparam logic [7:0] STATUS_RST = 8'h04;
   localparam logic [7:0] SERIAL_RST = 8'h00;
   localparam int MODE_A_LSB = 0;
   localparam int MODE_B_LSB = 2;
   localparam int FLAG_A_BIT = 4;
   localparam int FLAG_B_BIT = 5;
   localparam int STATUS_MASK_BIT = 2;
   localparam int SERIAL_EN_BIT = 0;
   localparam int LINE_A_BIT = 4;
   localparam int LINE_B_BIT = 5;
   localparam logic [1:0] MODE_INTERVAL = 2'h0;
   localparam logic [1:0] MODE_A_PULSE = 2'h1;
   localparam logic [1:0] MODE_EVENT = 2'h2;
   localparam logic [1:0] MODE_A_WIDTH = 2'h3;
   localparam logic [1:0] MODE_B_ASYM = 2'h1;
   localparam logic [1:0] MODE_B_RETRIG = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   //---------------------------------------------------------------------------
   // Timing.
   //---------------------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int INIT_CYCLES = 16;
   localparam int RESET_HOLD_CYCLES = 8;
   localparam logic [4:0] INIT_LAST = 5'(INIT_CYCLES - 1);

   //---------------------------------------------------------------------------
   // Types.
   //---------------------------------------------------------------------------
   typedef enum logic {DTB_GAP, DTB_PULSE} dtb_phase_t;

   // One accepted register write: index, data byte and a valid flag.
   typedef struct packed {
      logic en;
      logic [7:0] idx;
      logic [7:0] data;
   } dtb_wr_t;

   // Down count that reloads from the latch instead of wrapping to ffff.
   function automatic logic [15:0] dtb_step(input logic [15:0] count,
                                            input logic [15:0] latch);
      dtb_step = (count == 16'h0000) ? latch : count - 16'h0001;
   endfunction : dtb_step

endpackage : dtb_pkg

// >>> src/dtb_timer.sv
// Two-counter timer: Counter A rate source and width measurement, Counter B.
`timescale 1ns/10ps
module dtb_timer (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // AXI4-Lite write address and data.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer pins.
   input wire logic timer_a_line,
   input wire logic timer_b_in,
   output logic timer_b_out,
   output logic timer_b_oe_n,
   // Port latches, interrupt mask and serial rate tick.
   output logic [7:0] port_a,
   output logic [7:0] port_b,
   output logic irq_mask,
   output logic rate_tick
);

   //---------------------------------------------------------------------------
   // Declarations.
   //---------------------------------------------------------------------------
   logic [4:0] init_count; // Cycles of the post-reset sequence so far.
   logic init_done; // High once the sequence has run out.
   logic [7:0] mode_control; // Mode bits, Counter A in 1:0, Counter B in 3:2.
   logic [7:0] interrupt_enable; // Enables, stored for software only.
   logic [7:0] interrupt_flags; // Sticky underflow flags.
   logic [7:0] proc_status; // Status copy holding the interrupt mask.
   logic [7:0] serial_ctrl; // Serial channel enable.
   logic [15:0] latch_a; // Counter A reload value.
   logic [15:0] count_a; // Counter A.
   logic [7:0] latch_b_low;
   logic [7:0] latch_b_high;
   logic [15:0] latch_c; // Pulse width in asymmetrical mode.
   logic [15:0] count_b; // Counter B.
   dtb_pkg::dtb_phase_t phase_b; // Which latch period Counter B is timing.
   logic a_meta, a_sync, a_prev; // timer_a_line synchroniser and edge memory.
   logic b_meta, b_sync, b_prev; // timer_b_in synchroniser and edge memory.
   logic [7:0] aw_idx; // Held write index.
   logic aw_full, aw_bad; // Write address held, and whether unmapped.
   logic [7:0] w_data;
   logic w_strb0;
   logic w_full;
   dtb_pkg::dtb_wr_t wr; // Write performed this cycle.
   logic aw_take, w_take, ar_take, do_wr;
   logic next_aw_full, next_w_full, next_rvalid;
   logic [7:0] ar_idx;
   logic rd_a_low, rd_b_low; // Reads with a flag-clearing side effect.
   logic [1:0] mode_a, mode_b;
   logic serial_en;
   logic dec_a, dec_b, uf_a, uf_b, rise_a, rise_b;
   logic wr_a_load, wr_b_load;
   logic [15:0] latch_b;

   //---------------------------------------------------------------------------
   // Combinational decode.
   //---------------------------------------------------------------------------
   assign latch_b = {latch_b_high, latch_b_low};
   assign mode_a = mode_control[dtb_pkg::MODE_A_LSB +: 2];
   assign mode_b = mode_control[dtb_pkg::MODE_B_LSB +: 2];
   assign serial_en = serial_ctrl[dtb_pkg::SERIAL_EN_BIT];
   assign rise_a = a_sync & ~a_prev;
   assign rise_b = b_sync & ~b_prev;
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign do_wr = aw_full & w_full & ~s_axi_bvalid;
   assign next_aw_full = (aw_full & ~do_wr) | aw_take;
   assign next_w_full = (w_full & ~do_wr) | w_take;
   assign next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
   assign ar_idx = s_axi_araddr[9:2];
   assign wr.en = do_wr & ~aw_bad & w_strb0;
   assign wr.idx = aw_idx;
   assign wr.data = w_data;
   assign wr_a_load = wr.en & (wr.idx == dtb_pkg::IDX_A_LOAD);
   assign wr_b_load = wr.en & (wr.idx == dtb_pkg::IDX_B_LOAD);
   assign rd_a_low = ar_take & (s_axi_araddr[31:0] == {22'h0, dtb_pkg::IDX_A_LOW, 2'h0});
   assign rd_b_low = ar_take & (s_axi_araddr[31:0] == {22'h0, dtb_pkg::IDX_B_LOW, 2'h0});
   assign uf_a = dec_a & (count_a == 16'h0000);
   assign uf_b = dec_b & (count_b == 16'h0000) &
                 ~(mode_b == dtb_pkg::MODE_B_RETRIG && rise_b);

   // Counter A decrement source; the serial channel overrides the mode.
   always_comb begin
      if (serial_en) begin
         dec_a = 1'b1;
      end else begin
         unique case (mode_a)
            dtb_pkg::MODE_EVENT: dec_a = rise_a;
            dtb_pkg::MODE_A_WIDTH: dec_a = ~a_sync;
            default: dec_a = 1'b1;
         endcase
      end
   end

   // Counter B decrement source; Latch C is used only in the asymmetrical mode.
   always_comb begin
      unique case (mode_b)
         dtb_pkg::MODE_EVENT: dec_b = rise_b;
         default: dec_b = 1'b1;
      endcase
   end

   //---------------------------------------------------------------------------
   // Pin synchronisers. The first stage feeds only the second.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         a_meta <= 1'b1;
         a_sync <= 1'b1;
         a_prev <= 1'b1;
         b_meta <= 1'b1;
         b_sync <= 1'b1;
         b_prev <= 1'b1;
      end else begin
         a_meta <= timer_a_line;
         a_sync <= a_meta;
         a_prev <= a_sync;
         b_meta <= timer_b_in;
         b_sync <= b_meta;
         b_prev <= b_sync;
      end
   end

   //---------------------------------------------------------------------------
   // Post-reset sequence. The bus stays closed until it has run.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         init_count <= 5'h00;
         init_done <= 1'b0;
      end else if (!init_done) begin
         init_count <= init_count + 5'h01;
         init_done <= (init_count == dtb_pkg::INIT_LAST);
      end
   end

   //---------------------------------------------------------------------------
   // AXI4-Lite write channels. Address and data are held until both are in.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_full <= 1'b0;
         aw_bad <= 1'b0;
         aw_idx <= 8'h00;
         w_full <= 1'b0;
         w_data <= 8'h00;
         w_strb0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_awready <= init_done & ~next_aw_full;
         s_axi_wready <= init_done & ~next_w_full;
         if (aw_take) begin
            aw_idx <= s_axi_awaddr[9:2];
            aw_bad <= ~mapped(s_axi_awaddr);
         end
         if (w_take) begin
            w_data <= s_axi_wdata[7:0];
            w_strb0 <= s_axi_wstrb[0];
         end
      end
   end

   // Write response, one cycle after both halves are held.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dtb_pkg::RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= aw_bad ? dtb_pkg::RESP_SLVERR : dtb_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // AXI4-Lite read channel. Data are captured at the address handshake.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= dtb_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= init_done & ~next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= {24'h00_0000, mapped(s_axi_araddr) ? read_mux(ar_idx) : 8'h00};
            s_axi_rresp <= mapped(s_axi_araddr) ? dtb_pkg::RESP_OKAY : dtb_pkg::RESP_SLVERR;
         end
      end
   end

   // True for an aligned address that lands on a register.
   function automatic logic mapped(input logic [31:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      mapped = (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0) &&
               ((idx >= dtb_pkg::IDX_A_LOW && idx <= dtb_pkg::IDX_A_LOAD) ||
                (idx >= dtb_pkg::IDX_B_LOW && idx <= dtb_pkg::IDX_SERIAL &&
                 idx != 8'h1f));
   endfunction : mapped

   // Read data. Counter reads have no effect on the count itself.
   function automatic logic [7:0] read_mux(input logic [7:0] idx);
      logic [7:0] port_a_view;
      port_a_view = port_a;
      port_a_view[dtb_pkg::LINE_A_BIT] = a_sync;
      port_a_view[dtb_pkg::LINE_B_BIT] = b_sync;
      unique case (idx)
         dtb_pkg::IDX_A_HIGH: read_mux = count_a[15:8];
         dtb_pkg::IDX_A_LOW, dtb_pkg::IDX_A_LOAD: read_mux = count_a[7:0];
         dtb_pkg::IDX_B_HIGH: read_mux = count_b[15:8];
         dtb_pkg::IDX_B_LOW, dtb_pkg::IDX_B_LOAD: read_mux = count_b[7:0];
         dtb_pkg::IDX_MODE: read_mux = mode_control;
         dtb_pkg::IDX_INT_EN: read_mux = interrupt_enable;
         dtb_pkg::IDX_INT_FLAG: read_mux = interrupt_flags;
         dtb_pkg::IDX_PORT_A: read_mux = port_a_view;
         dtb_pkg::IDX_PORT_B: read_mux = port_b;
         dtb_pkg::IDX_STATUS: read_mux = proc_status;
         dtb_pkg::IDX_SERIAL: read_mux = serial_ctrl;
         default: read_mux = 8'h00;
      endcase
   endfunction : read_mux

   //---------------------------------------------------------------------------
   // Control registers written by software.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode_control <= dtb_pkg::MODE_RST;
         interrupt_enable <= dtb_pkg::INT_EN_RST;
         proc_status <= dtb_pkg::STATUS_RST;
         port_a <= dtb_pkg::PORT_RST;
         port_b <= dtb_pkg::PORT_RST;
         serial_ctrl <= dtb_pkg::SERIAL_RST;
      end else if (wr.en) begin
         unique case (wr.idx)
            dtb_pkg::IDX_MODE: mode_control <= wr.data;
            dtb_pkg::IDX_INT_EN: interrupt_enable <= wr.data;
            dtb_pkg::IDX_STATUS: proc_status <= wr.data;
            dtb_pkg::IDX_PORT_A: port_a <= wr.data;
            dtb_pkg::IDX_PORT_B: port_b <= wr.data;
            dtb_pkg::IDX_SERIAL: serial_ctrl <= wr.data;
            default: ;
         endcase
      end
   end

   assign irq_mask = proc_status[dtb_pkg::STATUS_MASK_BIT];

   //---------------------------------------------------------------------------
   // Underflow flags. A set in the same cycle as a clear wins, so no event
   // is lost to a racing software clear.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         interrupt_flags <= dtb_pkg::INT_FLAG_RST;
      end else begin
         if (uf_a) begin
            interrupt_flags[dtb_pkg::FLAG_A_BIT] <= 1'b1;
         end else if (rd_a_low || wr_a_load) begin
            interrupt_flags[dtb_pkg::FLAG_A_BIT] <= 1'b0;
         end
         if (uf_b) begin
            interrupt_flags[dtb_pkg::FLAG_B_BIT] <= 1'b1;
         end else if (rd_b_low || wr_b_load) begin
            interrupt_flags[dtb_pkg::FLAG_B_BIT] <= 1'b0;
         end
      end
   end

   //---------------------------------------------------------------------------
   // Counter A and its latch. The serial rate comes from its underflows.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latch_a <= 16'hffff;
         count_a <= 16'hffff;
         rate_tick <= 1'b0;
      end else begin
         rate_tick <= uf_a & serial_en;
         if (wr.en && wr.idx == dtb_pkg::IDX_A_LOW) begin
            latch_a[7:0] <= wr.data;
         end else if (wr.en && wr.idx == dtb_pkg::IDX_A_HIGH) begin
            latch_a[15:8] <= wr.data;
         end
         if (wr_a_load) begin
            latch_a[15:8] <= wr.data;
            count_a <= {wr.data, latch_a[7:0]};
         end else if (dec_a) begin
            count_a <= dtb_pkg::dtb_step(count_a, latch_a);
         end
      end
   end

   //---------------------------------------------------------------------------
   // Latch B and Latch C. Latch B writes are allowed at any time; Latch C loads from a high-byte write only in asymmetrical mode.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latch_b_low <= 8'hff;
         latch_b_high <= 8'hff;
         latch_c <= 16'hffff;
      end else if (wr.en) begin
         if (wr.idx == dtb_pkg::IDX_B_LOW) begin
            latch_b_low <= wr.data;
         end
         if (wr.idx == dtb_pkg::IDX_B_HIGH || wr.idx == dtb_pkg::IDX_B_LOAD) begin
            latch_b_high <= wr.data;
         end
         if (wr.idx == dtb_pkg::IDX_B_HIGH && mode_b == dtb_pkg::MODE_B_ASYM) begin
            latch_c <= {wr.data, latch_b_low};
         end
      end
   end

   //---------------------------------------------------------------------------
   // Counter B. A load-and-start write beats a retrigger edge, which beats
   // a count step.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count_b <= 16'hffff;
         phase_b <= dtb_pkg::DTB_GAP;
      end else if (wr_b_load) begin
         count_b <= {wr.data, latch_b_low};
         phase_b <= dtb_pkg::DTB_GAP;
      end else if (mode_b == dtb_pkg::MODE_B_RETRIG && rise_b) begin
         count_b <= latch_b;
      end else if (uf_b && mode_b == dtb_pkg::MODE_B_ASYM) begin
         count_b <= (phase_b == dtb_pkg::DTB_GAP) ? latch_c : latch_b;
         phase_b <= (phase_b == dtb_pkg::DTB_GAP) ? dtb_pkg::DTB_PULSE : dtb_pkg::DTB_GAP;
      end else if (dec_b) begin
         count_b <= dtb_pkg::dtb_step(count_b, latch_b);
      end
   end

   //---------------------------------------------------------------------------
   // timer_b_line drive. The pin is driven only in asymmetrical mode; in
   // the other modes it is an input so an external source can toggle it.
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         timer_b_out <= 1'b1;
         timer_b_oe_n <= 1'b1;
      end else begin
         timer_b_oe_n <= ~(mode_b == dtb_pkg::MODE_B_ASYM);
         if (mode_b != dtb_pkg::MODE_B_ASYM) begin
            timer_b_out <= 1'b1;
         end else if (wr_b_load) begin
            timer_b_out <= 1'b0;
         end else if (uf_b) begin
            timer_b_out <= (phase_b == dtb_pkg::DTB_GAP);
         end
      end
   end

endmodule : dtb_timer

// >>> verif/dtb_sva.sv
// Port assertions for the timer block.
`timescale 1ns/10ps
module dtb_sva (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Reset defaults.
   input wire logic [7:0] port_a,
   input wire logic [7:0] port_b,
   input wire logic irq_mask
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // The reset check must run while reset is high, so it drops the default disable.
   a_port_reset: assert property (disable iff (1'b0) reset |=>
      port_a == 8'hff && port_b == 8'hff && irq_mask) else $error("ports not set by reset");
   a_init_wait: assert property ($fell(reset) |->
      !s_axi_awready [*8] ##[1:12] s_axi_awready) else $error("bus opened off time");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address taken twice");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
endmodule : dtb_sva
bind dtb_timer dtb_sva u_sva (.sys_clk(sys_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .port_a(port_a), .port_b(port_b), .irq_mask(irq_mask));

// >>> verif/dtb_pins.sv
// Pulse sources and load on the two timer pins.
`timescale 1ns/10ps
module dtb_pins (
   // Levels commanded by the bench.
   input wire logic a_lvl,
   input wire logic b_lvl,
   // Block side of the pins.
   input wire logic timer_b_out,
   input wire logic timer_b_oe_n,
   output logic timer_a_line,
   output logic timer_b_in
);
   // The B source yields the wire while the block drives it.
   assign timer_a_line = a_lvl;
   assign timer_b_in = timer_b_oe_n ? b_lvl : timer_b_out;
endmodule : dtb_pins

// >>> verif/dtb_timer_bench.sv
// Self-checking bench for the timer block.
`timescale 1ns/10ps
module dtb_timer_bench;
   logic sys_clk, reset, awv, wv, bvalid, bready, arv, arready, rvalid, rready;
   logic awready, wready, a_lvl, b_lvl, ta, tb_in, tb_out, tb_oe_n, irq_mask, rate_tick;
   logic [1:0] bresp, rresp;
   logic [7:0] port_a, port_b, v, w;
   logic [31:0] awaddr, wdata, araddr, rdata;
   int err_count, n_tests, cyc, t, n;
   dtb_timer DUT (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_a_line(ta), .timer_b_in(tb_in),
      .timer_b_out(tb_out), .timer_b_oe_n(tb_oe_n), .port_a(port_a),
      .port_b(port_b), .irq_mask(irq_mask), .rate_tick(rate_tick));
   dtb_pins pins (.a_lvl(a_lvl), .b_lvl(b_lvl), .timer_b_out(tb_out),
      .timer_b_oe_n(tb_oe_n), .timer_a_line(ta), .timer_b_in(tb_in));
   // ------
   // Clock and a watchdog; the run needs about 900 cycles.
   // ------
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Write holds each channel until taken, then waits for the answer.
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge sys_clk);
      awaddr <= {22'h0, i, 2'h0};
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr
   // Read returns the byte and notes the cycle it was taken in.
   task automatic rd(input logic [7:0] i, output logic [7:0] d);
      @(posedge sys_clk);
      araddr <= {22'h0, i, 2'h0};
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arv <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata[7:0];
      t = cyc;
   endtask : rd
   task automatic t_reset;
      chk(port_a & port_b, 8'hff);
      chk({7'h0, irq_mask}, 8'h1);
      rd(8'h20, v);
      chk(v, 8'he0);
      rd(8'h22, v);
      chk(v, 8'h00);
      rd(8'h3f, v);
      chk({6'h0, rresp}, 8'h2);
      rd(8'h21, v);
      chk(v, 8'h00);
      wr(8'h3f, 8'h00);
      chk({6'h0, bresp}, 8'h2);
      wr(8'h21, 8'h5a);
      chk({6'h0, bresp}, 8'h0);
      rd(8'h21, v);
      chk(v, 8'h5a);
   endtask : t_reset
   task automatic t_intv;
      wr(8'h1c, 8'h40);
      wr(8'h1e, 8'h01);
      rd(8'h1d, v);
      chk(v, 8'h01);
      rd(8'h1c, v);
      n = t;
      rd(8'h1e, w);
      chk(v - w, 8'(t - n));
      repeat (330) @(posedge sys_clk);
      rd(8'h22, v);
      chk({7'h0, v[5]}, 8'h1);
      rd(8'h1d, v);
      chk(v, 8'h01);
      rd(8'h1c, v);
      rd(8'h22, v);
      chk({7'h0, v[5]}, 8'h0);
   endtask : t_intv
   task automatic t_retrig;
      wr(8'h20, 8'hec);
      wr(8'h1e, 8'h00);
      repeat (20) begin
         b_lvl <= ~b_lvl;
         repeat (10) @(posedge sys_clk);
      end
      rd(8'h22, v);
      chk({7'h0, v[5]}, 8'h0);
      repeat (80) @(posedge sys_clk);
      rd(8'h22, v);
      chk({7'h0, v[5]}, 8'h1);
   endtask : t_retrig
   task automatic t_event;
      wr(8'h20, 8'he8);
      wr(8'h1e, 8'h00);
      rd(8'h1c, v);
      // Edges at the fastest legal rate.
      repeat (5) begin
         b_lvl <= 1'b1;
         @(posedge sys_clk);
         b_lvl <= 1'b0;
         @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      rd(8'h1c, w);
      chk(v - w, 8'h05);
   endtask : t_event
   task automatic t_asym;
      wr(8'h20, 8'he4);
      wr(8'h1c, 8'h03);
      wr(8'h1d, 8'h00);
      wr(8'h1c, 8'h05);
      wr(8'h1e, 8'h00);
      chk({6'h0, tb_oe_n, tb_out}, 8'h0);
      do @(posedge sys_clk); while (tb_out !== 1'b1);
      for (int lvl = 1; lvl >= 0; lvl--) begin
         n = 0;
         while (tb_out === 1'(lvl)) begin
            @(posedge sys_clk);
            n++;
         end
         chk(8'(n), lvl ? 8'h04 : 8'h06);
      end
   endtask : t_asym
   task automatic t_width;
      wr(8'h20, 8'he3);
      a_lvl <= 1'b1;
      wr(8'h18, 8'h00);
      wr(8'h1a, 8'h01);
      rd(8'h19, v);
      chk(v, 8'h01);
      rd(8'h23, v);
      chk({7'h0, v[4]}, 8'h1);
      a_lvl <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rd(8'h19, v);
      chk(v, 8'h00);
      rd(8'h22, w);
      chk({7'h0, w[4]}, 8'h0);
      // Line high would freeze the count unless the serial path forces the clock.
      a_lvl <= 1'b1;
      wr(8'h18, 8'h03);
      wr(8'h1a, 8'h00);
      wr(8'h26, 8'h01);
      do @(posedge sys_clk); while (rate_tick !== 1'b1);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rate_tick !== 1'b1);
      chk(8'(n), 8'h04);
   endtask : t_width
   task automatic final_report;
      $display("Checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   initial begin
      reset = 1'b1;
      {awv, wv, bready, arv, rready, a_lvl, b_lvl} = 7'h0;
      {awaddr, wdata, araddr} = 96'h0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      do @(posedge sys_clk); while (awready !== 1'b1);
      t_reset();
      t_intv();
      t_retrig();
      t_event();
      t_asym();
      t_width();
      final_report();
   end
endmodule : dtb_timer_bench
